//--- logic/shsalu_consts.vh
/*
 * Constants for the packed-lane halving/select datapath: operation codes,
 * lane widths and the result reset value. Definitions only; assumes inclusion
 * by bare name from the design files.
 */
`ifndef SHSALU_CONSTS_VH
`define SHSALU_CONSTS_VH

// Operation codes on op_sel
`define SHSALU_OP_W          3
`define SHSALU_OP_PICK       3'h0
`define SHSALU_OP_ADD_HALF   3'h1
`define SHSALU_OP_ADD_BYTE   3'h2
`define SHSALU_OP_ADD_SUB_X  3'h3
`define SHSALU_OP_SUB_ADD_X  3'h4
`define SHSALU_OP_DIFF_HALF  3'h5
`define SHSALU_OP_DIFF_BYTE  3'h6

// Register index width and lane geometry
`define SHSALU_REG_W         4
`define SHSALU_WORD_W        32
`define SHSALU_BYTE_W        8
`define SHSALU_HALF_W        16
`define SHSALU_LANE_FLAGS_W  4

// Reset value of the result register
`define SHSALU_RESULT_RST    32'h0000_0000

`endif

//--- logic/shsalu_lane.v
/*
 * One signed halving lane: forms a +/- b one bit wider than the lane and
 * drops the low bit by an arithmetic shift right.
 * Assumes operands are two's complement and purely combinational use.
 */
`timescale 1ns/1ps

module shsalu_lane #(
   parameter W = 8                       // Lane width in bits
) (
   input  wire [W-1:0] a,                // Minuend or first addend
   input  wire [W-1:0] b,                // Subtrahend or second addend
   input  wire         sub,              // 1 selects a - b
   output wire [W-1:0] half              // Halved signed result
);

   wire [W:0] ext_a;
   wire [W:0] ext_b;
   wire [W:0] wide;

   // Sign extension by one bit keeps the sum exact
   assign ext_a = {a[W-1], a};
   assign ext_b = {b[W-1], b};
   assign wide  = sub ? (ext_a - ext_b) : (ext_a + ext_b);
   // Arithmetic shift right by one halves the value
   assign half  = wide[W:1];

endmodule // shsalu_lane

//--- logic/shsalu_core.v
/*
 * Packed-lane halving add/subtract and byte-pick datapath for a processor
 * core. One registered result stage: an operation accepted at a rising edge
 * shows its result word and write request from that edge on, with a write
 * strobe of one cycle; result and index then stand until the next accepted
 * operation. Unused operation codes and failed conditions are dropped
 * without a write.
 * Assumes decode presents one operation per cycle with op_valid, that the
 * register file applies wr_en/wr_addr/result a cycle later, and that the
 * lane flag bits are kept by the flag logic outside. Operand indices of the
 * halving operations never name the stack pointer or program counter;
 * nothing here checks that.
 */
`timescale 1ns/1ps
`include "shsalu_consts.vh"

// Summary of operation
// - byte-pick takes first source byte when its lane flag is 1, else second.
// - without a destination field, the first source register is written.
// - byte-pick and halving adds leave all flags, lane flags included, unchanged.
// - halfword halving add sums two signed 16-bit lanes, halved per lane.
// - byte halving add sums four signed 8-bit lanes, halved per byte.
// - halving is an arithmetic right shift by one of each lane result.
// - add-sub-exchange top half is half of first top plus second bottom.
// - add-sub-exchange bottom half is half of first bottom minus second top.
// - sub-add-exchange top half is half of first top minus second bottom.
// - sub-add-exchange bottom half is half of first bottom plus second top.
// - both exchange operations leave all flags unchanged.
// - halving subtracts take second from first per lane, halve, keep flags.
module shsalu_core #(
   parameter REG_W = `SHSALU_REG_W       // Register index width
) (
   input  wire                            core_clk,         // Core clock
   input  wire                            rst_n,            // Async reset, active low
   input  wire                            op_valid,         // Operation issued this cycle
   input  wire [`SHSALU_OP_W-1:0]         op_sel,           // Operation code
   input  wire                            cond_pass,        // Condition code passed
   input  wire [`SHSALU_WORD_W-1:0]       first_src,        // First source value
   input  wire [`SHSALU_WORD_W-1:0]       second_src,       // Second source value
   input  wire [REG_W-1:0]                first_src_addr,   // First source index
   input  wire                            dest_given,       // Destination field present
   input  wire [REG_W-1:0]                dest_addr,        // Destination index
   input  wire [`SHSALU_LANE_FLAGS_W-1:0] lane_nonneg_flags, // Lane flags, read only
   output reg  [`SHSALU_WORD_W-1:0]       result,           // Result word
   output reg                             wr_en,            // Register write strobe
   output reg  [REG_W-1:0]                wr_addr,          // Register write index
   output wire                            flags_wr_en       // Flag update, never raised
);

   // Lane operands chosen per operation
   reg  [`SHSALU_WORD_W-1:0] byte_a;
   reg  [`SHSALU_WORD_W-1:0] byte_b;
   reg  [`SHSALU_WORD_W-1:0] half_a;
   reg  [`SHSALU_WORD_W-1:0] half_b;
   reg  [1:0]                half_sub;
   reg                       byte_sub;
   wire [`SHSALU_WORD_W-1:0] byte_half;
   wire [`SHSALU_WORD_W-1:0] half_half;
   wire [`SHSALU_WORD_W-1:0] pick_word;
   reg  [`SHSALU_WORD_W-1:0] next_result;
   wire                      is_known;

   // Decoded operation strobes and the write-back request
   wire                      op_pick;
   wire                      op_add_half;
   wire                      op_add_byte;
   wire                      op_add_sub_x;
   wire                      op_sub_add_x;
   wire                      op_diff_half;
   wire                      op_diff_byte;
   wire                      accept;
   reg  [REG_W-1:0]          next_wr_addr;

   // Lane counts across one word
   localparam N_BYTES  = `SHSALU_WORD_W / `SHSALU_BYTE_W;
   localparam N_HALVES = `SHSALU_WORD_W / `SHSALU_HALF_W;

   // None of these operations touch the flags
   assign flags_wr_en = 1'b0;

   // One strobe per decoded operation code
   assign op_pick      = (op_sel == `SHSALU_OP_PICK);
   assign op_add_half  = (op_sel == `SHSALU_OP_ADD_HALF);
   assign op_add_byte  = (op_sel == `SHSALU_OP_ADD_BYTE);
   assign op_add_sub_x = (op_sel == `SHSALU_OP_ADD_SUB_X);
   assign op_sub_add_x = (op_sel == `SHSALU_OP_SUB_ADD_X);
   assign op_diff_half = (op_sel == `SHSALU_OP_DIFF_HALF);
   assign op_diff_byte = (op_sel == `SHSALU_OP_DIFF_BYTE);

   // Codes outside the set above are dropped without a write
   assign is_known = op_pick | op_add_half | op_add_byte | op_add_sub_x
                   | op_sub_add_x | op_diff_half | op_diff_byte;

   // Taken only with a passed condition and a known code
   assign accept = op_valid & cond_pass & is_known;

   // Operand steering for the halfword and byte lanes
   always @* begin
      half_a   = first_src;
      half_b   = second_src;
      half_sub = 2'b00;
      byte_a   = first_src;
      byte_b   = second_src;
      byte_sub = 1'b0;
      case (op_sel)
         `SHSALU_OP_PICK: begin
            // Lane units unused; the pick path carries the result
            half_sub = 2'b00;
         end

         `SHSALU_OP_ADD_HALF: begin
            // Both halfword lanes add straight across
            half_sub = 2'b00;
         end

         `SHSALU_OP_ADD_BYTE: begin
            // All four byte lanes add straight across
            byte_sub = 1'b0;
         end

         `SHSALU_OP_ADD_SUB_X: begin
            // Top: first top + second bottom; bottom: first bottom - second top
            half_b   = {second_src[15:0], second_src[31:16]};
            half_sub = 2'b01;
         end

         `SHSALU_OP_SUB_ADD_X: begin
            // Top: first top - second bottom; bottom: first bottom + second top
            half_b   = {second_src[15:0], second_src[31:16]};
            half_sub = 2'b10;
         end

         `SHSALU_OP_DIFF_HALF: begin
            // Second source taken from the first in both halfword lanes
            half_sub = 2'b11;
         end

         `SHSALU_OP_DIFF_BYTE: begin
            // Second source taken from the first in all four byte lanes
            byte_sub = 1'b1;
         end

         default: begin
            // Unused code; the result is never written
            half_sub = 2'b00;
         end
      endcase
   end

   // Per-lane halving units and byte pick
   // Shared index for both lane loops
   genvar i;
   generate
      // Four byte lanes, each with its halving unit and pick multiplexer
      for (i = 0; i < N_BYTES; i = i + 1) begin : g_byte
         shsalu_lane #(
            .W    (`SHSALU_BYTE_W)
         ) u_lane (
            .a    (byte_a[i*8 +: 8]),
            .b    (byte_b[i*8 +: 8]),
            .sub  (byte_sub),
            .half (byte_half[i*8 +: 8])
         );
         // Lane flag steers this byte between the two sources
         assign pick_word[i*8 +: 8] = lane_nonneg_flags[i] ? first_src[i*8 +: 8]
                                                         : second_src[i*8 +: 8];
      end
      // Two halfword lanes for the halfword and exchange operations
      for (i = 0; i < N_HALVES; i = i + 1) begin : g_half
         shsalu_lane #(
            .W    (`SHSALU_HALF_W)
         ) u_lane (
            .a    (half_a[i*16 +: 16]),
            .b    (half_b[i*16 +: 16]),
            .sub  (half_sub[i]),
            .half (half_half[i*16 +: 16])
         );
      end
   endgenerate

   // Result selection
   always @* begin
      case (op_sel)
         `SHSALU_OP_PICK:      next_result = pick_word;
         `SHSALU_OP_ADD_HALF:  next_result = half_half;
         `SHSALU_OP_ADD_BYTE:  next_result = byte_half;
         `SHSALU_OP_ADD_SUB_X: next_result = half_half;
         `SHSALU_OP_SUB_ADD_X: next_result = half_half;
         `SHSALU_OP_DIFF_HALF: next_result = half_half;
         `SHSALU_OP_DIFF_BYTE: next_result = byte_half;
         default:              next_result = result;      // Unused code, never written
      endcase
   end

   // Destination falls back to the first source index
   always @* begin
      next_wr_addr = dest_given ? dest_addr : first_src_addr;
   end

   // Result stage and write-back request
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         // Registers clear to idle: no write pending
         result  <= `SHSALU_RESULT_RST;
         wr_en   <= 1'b0;
         wr_addr <= {REG_W{1'b0}};
      end else begin
         wr_en <= accept;
         // Result and index hold when nothing is taken
         if (accept) begin
            result  <= next_result;
            wr_addr <= next_wr_addr;
         end
      end
   end

endmodule // shsalu_core

//--- dv/shsalu_monitor.sv
/* Port checker for shsalu_core; assumes the bind below reaches every instance. */
`timescale 1ns/1ps
module shsalu_monitor #(
   parameter REG_W = 4                              // Register index width
) (
   input wire logic             core_clk,           // Core clock
   input wire logic             rst_n,              // Async reset, active low
   input wire logic             op_valid,           // Operation issued
   input wire logic             cond_pass,          // Condition passed
   input wire logic             dest_given,         // Destination field present
   input wire logic             wr_en,              // Register write strobe
   input wire logic             flags_wr_en,        // Flag update
   input wire logic [2:0]       op_sel,             // Operation code
   input wire logic [31:0]      first_src,          // First source value
   input wire logic [31:0]      second_src,         // Second source value
   input wire logic [31:0]      result,             // Result word
   input wire logic [REG_W-1:0] first_src_addr,     // First source index
   input wire logic [REG_W-1:0] dest_addr,          // Destination index
   input wire logic [REG_W-1:0] wr_addr,            // Register write index
   input wire logic [3:0]       lane_nonneg_flags   // Lane flags
);
   reg  [31:0] pa;
   reg  [31:0] pb;
   reg  [3:0]  pf;
   wire        acc = op_valid && cond_pass && op_sel != 3'h7;
   // Top byte sum and pick word, from issue-cycle operands
   wire [8:0]  s_b3 = {pa[31], pa[31:24]} + {pb[31], pb[31:24]};
   wire [31:0] pick_w = {pf[3] ? pa[31:24] : pb[31:24], pf[2] ? pa[23:16] : pb[23:16],
                         pf[1] ? pa[15:8] : pb[15:8], pf[0] ? pa[7:0] : pb[7:0]};
   // Lane sums and a difference one bit wider than the lane, from issue-cycle operands
   wire [16:0] s_tt = {pa[31], pa[31:16]} + {pb[31], pb[31:16]};
   wire [16:0] s_tb = {pa[31], pa[31:16]} + {pb[15], pb[15:0]};
   wire [16:0] s_bt = {pa[15], pa[15:0]} + {pb[31], pb[31:16]};
   wire [16:0] d_bb = {pa[15], pa[15:0]} - {pb[15], pb[15:0]};
   // Operands seen one cycle back
   always @(posedge core_clk) begin
      pa <= first_src;
      pb <= second_src;
      pf <= lane_nonneg_flags;
   end
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   accept_write_a: assert property (acc |=> wr_en) else $error("no write");
   refuse_hold_a: assert property (!acc |=> !wr_en && $stable(result) && $stable(wr_addr))
      else $error("refused op wrote");
   dest_select_a: assert property (acc |=> wr_addr == ($past(dest_given) ? $past(dest_addr) : $past(first_src_addr)))
      else $error("bad index");
   flags_kept_a: assert property (op_valid |=> !flags_wr_en [*2]) else $error("flags written");
   add_half_a: assert property (acc && op_sel == 3'h1 |=> result[31:16] == s_tt[16:1])
      else $error("half add");
   asx_top_a: assert property (acc && op_sel == 3'h3 |=> result[31:16] == s_tb[16:1]) else $error("asx top");
   sax_bot_a: assert property (acc && op_sel == 3'h4 |=> result[15:0] == s_bt[16:1]) else $error("sax bot");
   diff_low_a: assert property (acc && op_sel == 3'h5 |=> result[15:0] == d_bb[16:1]) else $error("diff");
   add_byte_a: assert property (acc && op_sel == 3'h2 |=> result[31:24] == s_b3[8:1]) else $error("byte add");
   pick_lanes_a: assert property (acc && op_sel == 3'h0 |=> result == pick_w) else $error("pick");
endmodule // shsalu_monitor
bind shsalu_core shsalu_monitor #(
   .REG_W (REG_W)
) mon (
   .core_clk          (core_clk),
   .rst_n             (rst_n),
   .op_valid          (op_valid),
   .cond_pass         (cond_pass),
   .dest_given        (dest_given),
   .wr_en             (wr_en),
   .flags_wr_en       (flags_wr_en),
   .op_sel            (op_sel),
   .first_src         (first_src),
   .second_src        (second_src),
   .result            (result),
   .first_src_addr    (first_src_addr),
   .dest_addr         (dest_addr),
   .wr_addr           (wr_addr),
   .lane_nonneg_flags (lane_nonneg_flags)
);

//--- dv/shsalu_issue_model.sv
/* Decode and register-read side; assumes calls start just after a rising edge. */
`timescale 1ns/1ps
module shsalu_issue_model (
   input  wire        core_clk,           // Core clock
   output reg         op_valid,           // Operation issued
   output reg         cond_pass,          // Condition passed
   output reg         dest_given,         // Destination field present
   output reg  [2:0]  op_sel,             // Operation code
   output reg  [31:0] first_src,          // First source value
   output reg  [31:0] second_src,         // Second source value
   output reg  [3:0]  first_src_addr,     // First source index
   output reg  [3:0]  dest_addr,          // Destination index
   output reg  [3:0]  lane_nonneg_flags   // Lane flags
);
   // Quiet issue side before the first operation
   initial begin
      {op_valid, cond_pass, dest_given, op_sel} = 6'h00;
      {first_src, second_src} = 64'h0;
      {first_src_addr, dest_addr, lane_nonneg_flags} = 12'h000;
   end
   // One op held across one edge
   task issue(input [2:0] op, input c, input [31:0] a, input [31:0] b, input d, input [3:0] f);
      begin
         {op_valid, op_sel, cond_pass, first_src, second_src, dest_given} = {1'b1, op, c, a, b, d};
         {first_src_addr, dest_addr, lane_nonneg_flags} = {4'h3, 4'h9, f}; // Never 13 to 15
         @(posedge core_clk);
         #1;
      end
   endtask
   // Released operands show a changing pattern
   task idle;
      begin
         op_valid = 1'b0;
         first_src = ~first_src;
         second_src = ~second_src;
         @(posedge core_clk);
         #1;
      end
   endtask
endmodule // shsalu_issue_model

//--- dv/test_simd_halving_select_alu.sv
/* Bench for shsalu_core; assumes the issue model and checker bind compile with it. */
`timescale 1ns/1ps
module test_simd_halving_select_alu;
   reg core_clk = 1'b0;
   reg rst_n = 1'b0;
   integer n_errors = 0;
   integer n_tests = 0;
   integer k;
   reg [31:0] keep;
   wire op_valid, cond_pass, dest_given, wr_en, flags_wr_en;
   wire [2:0] op_sel;
   wire [31:0] first_src, second_src, result;
   wire [3:0] first_src_addr, dest_addr, lane_nonneg_flags, wr_addr;
   always #2.5 core_clk = ~core_clk;
   shsalu_issue_model P (
      .core_clk          (core_clk),
      .op_valid          (op_valid),
      .cond_pass         (cond_pass),
      .dest_given        (dest_given),
      .op_sel            (op_sel),
      .first_src         (first_src),
      .second_src        (second_src),
      .first_src_addr    (first_src_addr),
      .dest_addr         (dest_addr),
      .lane_nonneg_flags (lane_nonneg_flags)
   );
   shsalu_core DUT (
      .core_clk          (core_clk),
      .rst_n             (rst_n),
      .op_valid          (op_valid),
      .op_sel            (op_sel),
      .cond_pass         (cond_pass),
      .first_src         (first_src),
      .second_src        (second_src),
      .first_src_addr    (first_src_addr),
      .dest_given        (dest_given),
      .dest_addr         (dest_addr),
      .lane_nonneg_flags (lane_nonneg_flags),
      .result            (result),
      .wr_en             (wr_en),
      .wr_addr           (wr_addr),
      .flags_wr_en       (flags_wr_en)
   );
   // Halved lane sum or difference, one bit wider
   function [15:0] hv(input [16:0] x, y, input s);
      hv = (s ? x - y : x + y) >> 1;
   endfunction
   function [31:0] want(input [2:0] op, input [31:0] a, input [31:0] b, input [3:0] f);
      integer i;
      begin
         for (i = 0; i < 4; i = i + 1)
            want[8*i+:8] = op == 3'h0 ? (f[i] ? a[8*i+:8] : b[8*i+:8])
               : hv({a[8*i+7], a[8*i+:8]}, {b[8*i+7], b[8*i+:8]}, op == 3'h6);
         if (op == 3'h1 || op == 3'h5)
            want = {hv({a[31], a[31:16]}, {b[31], b[31:16]}, op[2]), hv({a[15], a[15:0]}, {b[15], b[15:0]}, op[2])};
         if (op == 3'h3 || op == 3'h4)
            want = {hv({a[31], a[31:16]}, {b[15], b[15:0]}, op[2]), hv({a[15], a[15:0]}, {b[31], b[31:16]}, !op[2])};
      end
   endfunction
   task chk(input [39:0] g, e);
      begin
         n_tests = n_tests + 1;
         if (g !== e) begin
            n_errors = n_errors + 1;
            $display("mismatch at %0t: got %h want %h", $time, g, e);
         end
      end
   endtask
   // All seven ops back to back on lane boundary values
   task t_ops;
      for (k = 0; k < 7; k = k + 1) begin
         P.issue(k[2:0], 1'b1, 32'h7fff_807f, 32'h7fff_8081, 1'b1, 4'h5);
         chk(result, want(k[2:0], 32'h7fff_807f, 32'h7fff_8081, 4'h5));
         chk({flags_wr_en, wr_en, wr_addr}, 32'h19);
      end
   endtask
   // No destination field, then a failed condition and an unused code
   task t_dest_refuse;
      begin
         P.issue(3'h0, 1'b1, 32'h1122_3344, 32'h5566_7788, 1'b1, 4'ha);
         chk(result, want(3'h0, 32'h1122_3344, 32'h5566_7788, 4'ha));
         P.issue(3'h2, 1'b1, 32'h8000_0180, 32'h80ff_7f80, 1'b0, 4'h5);
         chk(wr_addr, 32'h3);
         keep = result;
         P.issue(3'h1, 1'b0, 32'h1234_5678, 32'h1111_1111, 1'b1, 4'h5);
         chk({wr_en, result}, {1'b0, keep});
         P.issue(3'h7, 1'b1, 32'h1234_5678, 32'h1111_1111, 1'b1, 4'h5);
         chk({wr_en, result, wr_addr}, {1'b0, keep, 4'h3});
      end
   endtask
   task results;
      begin
         $display("errors %0d tests %0d", n_errors, n_tests);
         if (n_errors == 0 && n_tests > 0) $display("All tests passed");
         else $display("Some tests failed");
         $finish;
      end
   endtask
   initial begin
      repeat (3) @(posedge core_clk);
      #1 rst_n = 1'b1;
      @(posedge core_clk);
      #1 t_ops;
      P.idle;
      t_dest_refuse;
      P.idle;
      results;
   end
   initial begin
      // Tests take about 84 ns; about twelve times that is a hang
      #1000 n_errors = n_errors + 1;
      results;
   end
endmodule // test_simd_halving_select_alu
